// File: hw/tscc_link.sv
// Purpose: Serial slave port, runs on the master's shift clock
// Assumes: i_result is held still by the engine while a frame is open
// Notes: Chip enable low clears the frame state; shift clock may stop
`timescale 1ns/1ps
`default_nettype none
module tscc_link #(
  parameter int W = tscc_pkg::RES_W
) (
  input wire logic i_sclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_serial_control_in,
  input wire logic [W-1:0] i_result,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_shdn
);
  logic frame_rst;
  logic [4:0] edge_q;
  logic [W-1:0] sr_q;
  logic out_bit_q;
  logic shdn_bit_q;
  logic shdn_q;
  logic load_w;
  logic data_w;

  // Deselect holds the frame in reset, so stray edges do nothing
  assign frame_rst = i_sys_rst | ~i_ce;
  assign load_w = edge_q == 5'(tscc_pkg::LOAD_EDGE - 1);
  assign data_w = (edge_q >= 5'(tscc_pkg::DATA_FIRST_EDGE))
    && (edge_q < 5'(tscc_pkg::DATA_LAST_EDGE));

  // Rising edges: count and drive out the result
  always_ff @(posedge i_sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      edge_q <= '0;
      sr_q <= '0;
      out_bit_q <= 1'b0;
    end
    else
    begin
      if (edge_q != 5'(tscc_pkg::FRAME_EDGES))
        edge_q <= edge_q + 1'b1;
      if (edge_q == 5'(tscc_pkg::DATA_FIRST_EDGE - 1))
      begin
        sr_q <= i_result; // Snapshot taken late so the freeze has settled
        out_bit_q <= i_result[W-1];
      end
      else if (data_w)
      begin
        sr_q <= sr_q << 1;
        out_bit_q <= sr_q[W-2];
      end
    end
  end

  // Falling edges: only the power-down bit is kept
  always_ff @(negedge i_sclk or posedge frame_rst)
  begin
    if (frame_rst)
      shdn_bit_q <= tscc_pkg::SHDN_RST;
    else if (edge_q == 5'(tscc_pkg::SHDN_BIT_POS))
      shdn_bit_q <= i_serial_control_in;
  end

  // Control applied on the 15th rising edge, else untouched
  always_ff @(posedge i_sclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      shdn_q <= tscc_pkg::SHDN_RST;
    else if (i_ce && load_w)
      shdn_q <= shdn_bit_q;
  end

  assign o_serial_result_out = out_bit_q;
  assign o_serial_result_oe = i_ce; // Released on deselect
  assign o_shdn = shdn_q;

  a_ctrl_load: assert property (
    @(posedge i_sclk) disable iff (frame_rst)
    load_w |=> o_shdn == $past(shdn_bit_q))
    else $error("control bit not applied at edge 15");
  a_lead_zero: assert property (
    @(posedge i_sclk) disable iff (frame_rst)
    (edge_q == 5'd1) |-> !out_bit_q)
    else $error("leading bit is not zero");
  a_shift_data: assert property (
    @(posedge i_sclk) disable iff (frame_rst)
    data_w |=> out_bit_q == $past(sr_q[W-2]))
    else $error("serial bit not from result");
endmodule // tscc_link
`default_nettype wire

// File: hw/tscc_pkg.sv
// Purpose: Shared constants for the temperature conversion control block
// Assumes: Conversion engine clocked at 50 MHz
// Notes: Cycle counts derive from the printed times and the clock rate
package tscc_pkg;
  // Result and clock figures
  localparam int RES_W = 10;
  localparam int MCLK_MHZ = 50;
  // Conversion schedule in microseconds, then cycles (whole, 25 us typ)
  localparam int INTERVAL_US = 400;
  localparam int CONV_US = 25;
  localparam int INTERVAL_CYC = INTERVAL_US * MCLK_MHZ;
  localparam int CONV_CYC = CONV_US * MCLK_MHZ;
  // Approximation step spacing; leaves slack before the end
  localparam int SAR_STEP_CYC = CONV_CYC / (RES_W + 1);
  // Serial frame figures, counted in rising shift-clock edges
  localparam int FRAME_EDGES = 16;
  localparam int LOAD_EDGE = 15;
  localparam int SHDN_BIT_POS = 3;
  localparam int DATA_FIRST_EDGE = 2;
  localparam int DATA_LAST_EDGE = DATA_FIRST_EDGE + RES_W - 1;
  // Values after reset
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  localparam logic SHDN_RST = 1'b0;
  // Conversion sequencer states
  typedef enum logic [1:0] {ST_WAIT, ST_CONV, ST_SHDN} tscc_state_e;
endpackage

// File: hw/tscc_sar.sv
// Purpose: Successive-approximation search for the 10-bit result
// Assumes: Comparator input already synchronised to i_mclk
// Notes: Code is offset binary; caller turns it into two's complement
`timescale 1ns/1ps
`default_nettype none
module tscc_sar #(
  parameter int W = tscc_pkg::RES_W,
  parameter int STEP_CYC = tscc_pkg::SAR_STEP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic i_cmp,
  output logic [W-1:0] o_code,
  output logic o_busy
);
  localparam int SW = $clog2(STEP_CYC + 1);
  logic [W-1:0] code_q;
  logic [W-1:0] mask_q;
  logic [SW-1:0] step_q;
  logic busy_q;
  logic step_w;
  logic [W-1:0] keep_w;

  // Trial bit stays only while the sensed level is above the trial code
  assign step_w = busy_q && (step_q == SW'(STEP_CYC - 1));
  assign keep_w = i_cmp ? code_q : (code_q & ~mask_q);

  // One decision per step, MSB first
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      code_q <= '0;
      mask_q <= '0;
      step_q <= '0;
      busy_q <= 1'b0;
    end
    else if (i_start)
    begin
      code_q <= {1'b1, {(W-1){1'b0}}};
      mask_q <= {1'b1, {(W-1){1'b0}}};
      step_q <= '0;
      busy_q <= 1'b1;
    end
    else if (step_w)
    begin
      code_q <= keep_w | (mask_q >> 1);
      mask_q <= mask_q >> 1;
      step_q <= '0;
      busy_q <= !mask_q[0];
    end
    else if (busy_q)
      step_q <= step_q + 1'b1;
  end

  assign o_code = code_q;
  assign o_busy = busy_q;
endmodule // tscc_sar
`default_nettype wire

// File: hw/tscc_top.sv
// Purpose: Conversion scheduling and serial readout of the temperature
// Assumes: i_mclk stands in for the internal oscillator
// Notes: i_sclk is the master's shift clock, a separate domain
`timescale 1ns/1ps
`default_nettype none
module tscc_top #(
  parameter int INTERVAL_CYC = tscc_pkg::INTERVAL_CYC,
  parameter int CONV_CYC = tscc_pkg::CONV_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_ce,
  input wire logic i_serial_control_in,
  input wire logic i_cmp_above,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic [tscc_pkg::RES_W-1:0] o_dac_code,
  output logic o_sense_en,
  output logic [tscc_pkg::RES_W-1:0] o_result
);
  localparam int W = tscc_pkg::RES_W;
  localparam int CW = $clog2(INTERVAL_CYC + 1);
  // Step spacing follows the conversion length, so ten steps always fit
  localparam int STEP_CYC = CONV_CYC / (W + 1);

  tscc_pkg::tscc_state_e state_q;
  tscc_pkg::tscc_state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic ce_meta_q;
  logic ce_sync_q;
  logic ce_prev_q;
  logic shdn_meta_q;
  logic shdn_sync_q;
  logic cmp_meta_q;
  logic cmp_sync_q;
  logic [W-1:0] result_q;
  logic [W-1:0] pend_word_q;
  logic pend_q;
  logic link_shdn;
  logic [W-1:0] sar_code;
  logic sar_busy;
  logic xfer_end_w;
  logic conv_end_w;
  logic interval_end_w;
  logic start_w;
  logic pend_apply_w;
  logic [W-1:0] conv_word_w;

  // Serial port on the master's clock
  tscc_link #(
    .W(W)
  ) u_link (
    .i_sclk(i_sclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_serial_control_in(i_serial_control_in),
    .i_result(result_q),
    .o_serial_result_out(o_serial_result_out),
    .o_serial_result_oe(o_serial_result_oe),
    .o_shdn(link_shdn)
  );

  // Approximation engine, restarted with each conversion
  tscc_sar #(
    .W(W),
    .STEP_CYC(STEP_CYC)
  ) u_sar (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_start(start_w),
    .i_cmp(cmp_sync_q),
    .o_code(sar_code),
    .o_busy(sar_busy)
  );

  // Level crossings: chip enable, power-down bit and comparator
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ce_meta_q <= 1'b0;
      ce_sync_q <= 1'b0;
      ce_prev_q <= 1'b0;
      shdn_meta_q <= tscc_pkg::SHDN_RST;
      shdn_sync_q <= tscc_pkg::SHDN_RST;
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end
    else
    begin
      ce_meta_q <= i_ce;
      ce_sync_q <= ce_meta_q;
      ce_prev_q <= ce_sync_q;
      shdn_meta_q <= link_shdn;
      shdn_sync_q <= shdn_meta_q;
      cmp_meta_q <= i_cmp_above;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // Schedule events; a deselect marks the end of a transfer
  assign xfer_end_w = ce_prev_q && !ce_sync_q;
  assign conv_end_w = (state_q == tscc_pkg::ST_CONV)
    && (cnt_q == CW'(CONV_CYC - 1));
  assign interval_end_w = (state_q == tscc_pkg::ST_WAIT)
    && (cnt_q == CW'(INTERVAL_CYC - 1));
  assign start_w = (state_d == tscc_pkg::ST_CONV) && (cnt_d == '0);

  // Offset binary to two's complement, quarter degree per LSB
  assign conv_word_w = {~sar_code[W-1], sar_code[W-2:0]};
  assign pend_apply_w = pend_q && !ce_sync_q;

  // Next state; shutdown outranks every restart
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + 1'b1;
    unique case (state_q)
      tscc_pkg::ST_WAIT:
      begin
        if (shdn_sync_q)
          state_d = tscc_pkg::ST_SHDN;
        else if (xfer_end_w || interval_end_w)
        begin
          state_d = tscc_pkg::ST_CONV;
          cnt_d = '0;
        end
      end
      tscc_pkg::ST_CONV:
      begin
        if (shdn_sync_q)
          state_d = tscc_pkg::ST_SHDN;
        else if (xfer_end_w)
          cnt_d = '0; // Restart from scratch
        else if (conv_end_w)
          state_d = tscc_pkg::ST_WAIT; // Interval runs from start
      end
      tscc_pkg::ST_SHDN:
      begin
        cnt_d = '0; // Oscillator held still
        if (!shdn_sync_q)
          state_d = tscc_pkg::ST_CONV;
      end
    endcase
  end

  // Sequencer; reset parks it at the interval end, so the first edge
  // starts a real conversion instead of storing an idle code
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q <= tscc_pkg::ST_WAIT;
      cnt_q <= CW'(INTERVAL_CYC - 1); // Expires on the first edge
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Result store, frozen while a frame is open so readout stays whole;
  // a word finished mid-frame waits for the deselect
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      result_q <= tscc_pkg::RESULT_RST;
      pend_word_q <= tscc_pkg::RESULT_RST;
      pend_q <= 1'b0;
    end
    else if (conv_end_w && !shdn_sync_q && !xfer_end_w)
    begin
      if (ce_sync_q)
      begin
        pend_word_q <= conv_word_w;
        pend_q <= 1'b1;
      end
      else
      begin
        result_q <= conv_word_w;
        pend_q <= 1'b0;
      end
    end
    else if (pend_apply_w)
    begin
      result_q <= pend_word_q; // Aborted runs never reach here
      pend_q <= 1'b0;
    end
  end

  // Analog side powered only while converting
  assign o_sense_en = (state_q == tscc_pkg::ST_CONV);
  assign o_dac_code = sar_code;
  assign o_result = result_q;

  // Checks on the conversion engine
  sequence s_leave_shdn;
    (state_q == tscc_pkg::ST_SHDN) && !shdn_sync_q;
  endsequence

  sequence s_xfer_done;
    xfer_end_w && !shdn_sync_q;
  endsequence

  a_conv_bounded: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (state_q == tscc_pkg::ST_CONV) |-> (cnt_q < CW'(CONV_CYC)))
    else $error("conversion overran its length");

  a_interval_start: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (interval_end_w && !shdn_sync_q && !xfer_end_w)
    |=> (state_q == tscc_pkg::ST_CONV) && (cnt_q == '0))
    else $error("scheduled conversion not started");

  a_shdn_stops: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    shdn_sync_q |=> (state_q == tscc_pkg::ST_SHDN) && !o_sense_en)
    else $error("conversion runs in shutdown");

  a_shdn_result: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    ((state_q == tscc_pkg::ST_SHDN) && !pend_q) |=> $stable(result_q))
    else $error("result changed in shutdown");

  a_xfer_restart: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    s_xfer_done |=> (state_q == tscc_pkg::ST_CONV) && (cnt_q == '0))
    else $error("transfer end did not restart conversion");

  a_wake_restart: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    s_leave_shdn |=> (o_sense_en && sar_busy) [*2])
    else $error("leaving shutdown did not restart conversion");

  a_result_hold: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    !$stable(result_q) |-> $past(conv_end_w || pend_apply_w))
    else $error("result changed without a finished conversion");

  a_sar_done: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    conv_end_w |-> !sar_busy)
    else $error("approximation unfinished at conversion end");

  // Further checks: idle engine, result store, frame freeze and approximation start
  sequence s_conv_finish;
    conv_end_w && !shdn_sync_q && !xfer_end_w;
  endsequence

  a_idle_quiet: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (state_q == tscc_pkg::ST_WAIT) |-> !sar_busy)
    else $error("approximation running while idle");

  a_conv_idle: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    s_conv_finish |=> (state_q == tscc_pkg::ST_WAIT) && !o_sense_en)
    else $error("engine did not idle after conversion");

  a_result_store: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    s_conv_finish ##0 !ce_sync_q |=> o_result == $past(conv_word_w))
    else $error("finished word not stored");

  a_pend_apply: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (pend_apply_w && !conv_end_w) |=> o_result == $past(pend_word_q))
    else $error("held word not stored after deselect");

  a_frame_freeze: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    ce_sync_q |=> $stable(o_result))
    else $error("result changed while a frame was open");

  a_conv_start: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    start_w |=> sar_busy && (o_dac_code == {1'b1, {(W-1){1'b0}}}))
    else $error("approximation not started at conversion start");
endmodule // tscc_top
`default_nettype wire

// File: test/tb_temp_sensor_conversion_control.sv
// Purpose: Self-checking bench for the conversion control block
// Assumes: Shortened interval; conversion length kept at package value
// Notes: Comparator is modelled from the trial code and a set level
`timescale 1ns/1ps
`default_nettype none
module tb_temp_sensor_conversion_control;
  localparam int INTERVAL = 4000;
  localparam int CONV = tscc_pkg::CONV_CYC;
  localparam int LIMIT = 30000;
  localparam logic [9:0] L1 = 10'h2C8;
  localparam logic [9:0] L2 = 10'h19C;
  localparam logic [9:0] L3 = 10'h3F0;
  logic i_mclk, i_sys_rst, i_cmp_above, ce, sclk, ctl_in, res_out, oe, sense;
  logic [9:0] dac, res, lvl;
  wire logic res_line;
  int n_fail, comparisons, cycles;
  // Released output floats
  assign res_line = oe ? res_out : 1'bz;
  tscc_top #(.INTERVAL_CYC(INTERVAL), .CONV_CYC(CONV)) dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_ce(ce),
    .i_serial_control_in(ctl_in), .i_cmp_above(i_cmp_above),
    .o_serial_result_out(res_out), .o_serial_result_oe(oe),
    .o_dac_code(dac), .o_sense_en(sense), .o_result(res));
  tscc_master_model m (.o_ce(ce), .o_sclk(sclk),
    .o_serial_control_in(ctl_in), .i_serial_result_out(res_line));
  // Clock, 20 ns period
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Comparator model, changed off the sampling edge
  always @(negedge i_mclk)
    i_cmp_above <= (lvl >= dac);
  // Hang guard
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [9:0] word_of(input logic [9:0] l);
    return {~l[9], l[8:0]};
  endfunction
  // Leading zero, ten bits, last bit held
  function automatic logic [15:0] frame_of(input logic [9:0] w);
    return {1'b0, w, {5{w[0]}}};
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Scheduled conversions and a plain read
  task automatic t_schedule();
    logic [15:0] rx;
    wait_cyc(1300);
    chk_bit("idle after conv", 1'b0, sense);
    wait_cyc(2690);
    chk_bit("idle before tick", 1'b0, sense);
    wait_cyc(30);
    chk_bit("tick started", 1'b1, sense);
    wait_cyc(CONV);
    chk_word("result", {6'h00, word_of(L1)}, {6'h00, res});
    chk_word("trial code", {6'h00, L1}, {6'h00, dac});
    m.run_frame(16'h0000, 16, rx);
    chk_word("read", frame_of(word_of(L1)), rx);
  endtask
  // Enter shutdown with don't-care bits set, read while asleep
  task automatic t_shutdown();
    logic [15:0] rx;
    m.run_frame(16'hE000, 16, rx);
    chk_word("read to sleep", frame_of(word_of(L1)), rx);
    wait_cyc(20);
    chk_bit("asleep", 1'b0, sense);
    lvl = L2;
    wait_cyc(INTERVAL + CONV);
    chk_bit("still asleep", 1'b0, sense);
    chk_word("kept", {6'h00, word_of(L1)}, {6'h00, res});
    m.run_frame(16'h2000, 16, rx);
    chk_word("read asleep", frame_of(word_of(L1)), rx);
  endtask
  // Leave shutdown, read early, then see the fresh result
  task automatic t_wake();
    logic [15:0] rx;
    m.run_frame(16'hC000, 16, rx);
    chk_word("read to wake", frame_of(word_of(L1)), rx);
    wait_cyc(10);
    chk_bit("woken", 1'b1, sense);
    m.run_frame(16'h0000, 16, rx);
    chk_word("early read", frame_of(word_of(L1)), rx);
    wait_cyc(CONV + 20);
    chk_word("fresh", {6'h00, word_of(L2)}, {6'h00, res});
  endtask
  // Deselected edges and a frame cut before edge 15
  task automatic t_abort();
    logic [15:0] rx;
    m.stray_clocks(16);
    chk_bit("oe idle", 1'b0, oe);
    m.run_frame(16'h2000, 14, rx);
    chk_word("short read", frame_of(word_of(L2)) & 16'hFFFC, rx);
    wait_cyc(20);
    chk_bit("not asleep", 1'b1, sense);
    lvl = L3;
    wait_cyc(CONV + 20);
    m.run_frame(16'h0000, 16, rx);
    chk_word("after restart", frame_of(word_of(L3)), rx);
  endtask
  // Main sequence
  initial
  begin
    i_sys_rst = 1'b1;
    lvl = L1;
    wait_cyc(16);
    chk_word("reset result", 16'h0000, {6'h00, res});
    chk_bit("reset oe", 1'b0, oe);
    i_sys_rst = 1'b0;
    t_schedule();
    t_shutdown();
    t_wake();
    t_abort();
    print_verdict();
  end
endmodule // tb_temp_sensor_conversion_control
`default_nettype wire

// File: test/tscc_master_model.sv
// Purpose: Serial bus master model driving the link of the block
// Assumes: Shift clock idles low, 64 ns period, inside frames and in stray_clocks while deselected
// Notes: The bench calls run_frame and stray_clocks hierarchically
`timescale 1ns/1ps
`default_nettype none
module tscc_master_model (
  output logic o_ce,
  output logic o_sclk,
  output logic o_serial_control_in,
  input wire logic i_serial_result_out
);
  localparam int HALF_NS = 32;
  // Idle: deselected, clock still
  initial
  begin
    o_ce = 1'b0;
    o_sclk = 1'b0;
    o_serial_control_in = 1'b0;
  end
  // One frame; control sent first bit first, rx kept in receive order
  task automatic run_frame(input logic [15:0] ctl, input int edges,
                           output logic [15:0] rx);
    rx = 16'h0000;
    o_ce = 1'b1;
    #100; // Lets the result freeze settle
    for (int k = 0; k < edges; k++)
    begin
      o_sclk = 1'b1;
      o_serial_control_in = ctl[15-k];
      #(HALF_NS / 2);
      rx[15-k] = i_serial_result_out;
      #(HALF_NS / 2);
      o_sclk = 1'b0;
      #HALF_NS;
    end
    o_ce = 1'b0;
    o_serial_control_in = ~o_serial_control_in; // No stale value
    #(4 * HALF_NS); // Deselect long enough to cross to the engine
  endtask
  // Clock edges while deselected, data high
  task automatic stray_clocks(input int edges);
    o_serial_control_in = 1'b1;
    for (int k = 0; k < edges; k++)
    begin
      o_sclk = 1'b1;
      #HALF_NS;
      o_sclk = 1'b0;
      #HALF_NS;
    end
  endtask
endmodule // tscc_master_model
`default_nettype wire
